// ==== include/ldpm_pkg.sv ====
// Shared constants for the LED dimming and charge pump mode controller.
package ldpm_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  // System clock period in nanoseconds (25 MHz).
  localparam int CLK_PERIOD_NS = 40;
  // Shortest low pulse that counts as a dimming pulse, in ns.
  localparam int PROGRAM_LOW_TIME_MIN_NS = 200;
  // Least low time rounds up to whole cycles.
  localparam int PROGRAM_LOW_MIN_CYC =
    (PROGRAM_LOW_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Continuous low time that shuts the device down, in ns.
  localparam int LOW_TIME_TO_SHUTDOWN_NS = 1_500_000;
  localparam int SHUTDOWN_CYC = (LOW_TIME_TO_SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Delay before each pump step up, in ns.
  localparam int STEP_UP_DELAY_NS = 400_000;
  localparam int STEP_UP_CYC = (STEP_UP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_GAIN = 8'h08;
  // Control fields and reset values.
  localparam int CTRL_MASK_LSB = 0;
  localparam int CTRL_FORCE_1X_BIT = 4;
  localparam logic [3:0] CTRL_MASK_RESET = 4'hf;
  // Status field positions.
  localparam int ST_MODE_LSB = 0;
  localparam int ST_LEVEL_LSB = 2;
  localparam int ST_ACTIVE_BIT = 5;
  localparam int ST_THERMAL_BIT = 6;
  localparam int ST_OPEN_LSB = 8;
  localparam int ST_REG_LSB = 12;
  // ----------------------------------------------------------------
  // Gain levels, in eighths of the current set resistor gain
  // ----------------------------------------------------------------
  localparam int GAIN_LEVELS = 6;
  localparam logic [10:0] GAIN_FULL_X8 = 11'h420;
  // ----------------------------------------------------------------
  // Pump modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_1X, MODE_1P33X, MODE_1P5X, MODE_2X} ldpm_mode_t;
endpackage

// ==== rtl/ldpm_ctrl.sv ====
// LED dimming decoder, charge pump mode sequencer and fault handling, with an AHB-Lite slave.
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ldpm_ctrl #(
  parameter int CHANNELS = 4,
  parameter int SHUTDOWN_CYCLES = ldpm_pkg::SHUTDOWN_CYC,
  parameter int STEP_UP_CYCLES = ldpm_pkg::STEP_UP_CYC
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // One-wire enable and dimming input from the host.
  input wire logic enable_dim_input,
  // Analog indications, synchronous to hclk.
  input wire logic [CHANNELS-1:0] led_in_regulation,
  input wire logic [CHANNELS-1:0] led_open,
  input wire logic supply_ok_for_1x,
  input wire logic pump_output_overvoltage,
  input wire logic die_over_temp,
  input wire logic die_temp_recovered,
  // Controls to the analog section.
  output logic [CHANNELS-1:0] led_sink_enable,
  output logic [1:0] pump_mode,
  output logic pump_switch_enable,
  output logic [10:0] led_gain_x8,
  output logic device_active
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Counter width wide enough for the longest count.
  localparam int CW =
    $clog2((SHUTDOWN_CYCLES > STEP_UP_CYCLES ? SHUTDOWN_CYCLES : STEP_UP_CYCLES) + 1);
  localparam logic [CW-1:0] LOW_MIN = CW'(ldpm_pkg::PROGRAM_LOW_MIN_CYC);
  localparam logic [CW-1:0] SD_LIMIT = CW'(SHUTDOWN_CYCLES);
  localparam logic [CW-1:0] STEP_LIMIT = CW'(STEP_UP_CYCLES);
  logic en_prev; // Input level seen in the previous cycle.
  logic [CW-1:0] low_cnt; // Cycles the input has stayed low.
  logic [2:0] gain_level; // Dimming level index, 0 is full scale.
  logic [2:0] next_gain_level;
  logic thermal_trip; // Thermal shutdown in force.
  logic operating; // Enabled and not thermally tripped.
  ldpm_pkg::ldpm_mode_t mode; // Present pump mode.
  ldpm_pkg::ldpm_mode_t next_mode;
  logic [CW-1:0] step_cnt; // Step-up delay counter.
  logic [CW-1:0] next_step_cnt;
  logic [CHANNELS-1:0] ch_mask; // Software channel enable mask.
  logic force_1x; // Software hold of the pump in 1x.
  logic [CHANNELS-1:0] watched; // Channels that take part in regulation.
  logic need_step; // A watched channel is out of regulation.
  logic en_rise; // Rising edge on the enable input.
  logic wr_pend; // Write data phase pending.
  logic [7:0] wr_addr; // Address of the pending write.
  logic addr_ok; // Valid address phase on this slave.

  // ----------------------------------------------------------------
  // Enable and dimming input decode
  // ----------------------------------------------------------------
  // The previous level resets low, matching the idle wire, so leaving reset
  // never shows a false rising edge.
  assign en_rise = enable_dim_input && !en_prev;

  // Previous input level and low time counter; saturates so a long low is never misread.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_prev <= 1'b0;
      low_cnt <= '0;
    end else begin
      en_prev <= enable_dim_input;
      if (enable_dim_input) begin
        low_cnt <= '0;
      end else if (low_cnt != SD_LIMIT) begin
        low_cnt <= low_cnt + CW'(1);
      end
    end
  end

  // Enable state: rising from shutdown enables, a long low shuts down.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      device_active <= 1'b0;
    end else if (!enable_dim_input && low_cnt == SD_LIMIT - CW'(1)) begin
      device_active <= 1'b0;
    end else if (en_rise) begin
      device_active <= 1'b1;
    end
  end

  // Next dimming level. Only a low pulse of the least programming width counts;
  // glitches shorter than that leave the level alone.
  always_comb begin
    next_gain_level = gain_level;
    if (!device_active || (!enable_dim_input && low_cnt == SD_LIMIT - CW'(1))) begin
      next_gain_level = 3'h0;
    end else if (en_rise && low_cnt >= LOW_MIN) begin
      if (gain_level == 3'(ldpm_pkg::GAIN_LEVELS - 1)) begin
        next_gain_level = 3'h0;
      end else begin
        next_gain_level = gain_level + 3'h1;
      end
    end
  end

  // Dimming level and the gain it selects; each level halves the one before.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_level <= 3'h0;
      led_gain_x8 <= ldpm_pkg::GAIN_FULL_X8;
    end else begin
      gain_level <= next_gain_level;
      led_gain_x8 <= ldpm_pkg::GAIN_FULL_X8 >> next_gain_level;
    end
  end

  // ----------------------------------------------------------------
  // Thermal protection
  // ----------------------------------------------------------------
  // Trip on over-temperature; the sensor's recovered flag carries the hysteresis.
  // When both flags are high in one cycle the trip stays set, the safe choice.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thermal_trip <= 1'b0;
    end else if (die_over_temp) begin
      thermal_trip <= 1'b1;
    end else if (die_temp_recovered) begin
      thermal_trip <= 1'b0;
    end
  end

  // A thermal trip stops regulation but, unlike shutdown, keeps the dimming level.
  assign operating = device_active && !thermal_trip;

  // ----------------------------------------------------------------
  // LED sinks
  // ----------------------------------------------------------------
  // Sinks are off (high impedance) in shutdown and for open or masked channels.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_sink_enable <= '0;
    end else if (!operating) begin
      led_sink_enable <= '0;
    end else begin
      led_sink_enable <= ch_mask & ~led_open;
    end
  end

  // ----------------------------------------------------------------
  // Charge pump mode sequencer
  // ----------------------------------------------------------------
  // Open and masked channels drop out of both the sinks and the step-up vote.
  assign watched = ch_mask & ~led_open;
  assign need_step = |(watched & ~led_in_regulation);

  // Next mode and step delay. Steps go up one at a time after the delay,
  // and the only way down is straight to 1x.
  always_comb begin
    next_mode = mode;
    next_step_cnt = '0;
    if (!operating || pump_output_overvoltage) begin
      next_mode = ldpm_pkg::MODE_1X;
    end else if (watched == '0 || force_1x) begin
      next_mode = ldpm_pkg::MODE_1X;
    end else if (mode != ldpm_pkg::MODE_1X && supply_ok_for_1x) begin
      next_mode = ldpm_pkg::MODE_1X;
    end else if (!need_step) begin
      next_mode = mode;
    end else begin
      case (mode)
        ldpm_pkg::MODE_2X: begin
          next_mode = mode;
        end
        default: begin
          if (step_cnt == STEP_LIMIT - CW'(1)) begin
            next_mode = ldpm_pkg::ldpm_mode_t'(mode + 2'h1);
          end else begin
            next_step_cnt = step_cnt + CW'(1);
          end
        end
      endcase
    end
  end

  // Mode state and delay counter; reset lands in 1x before any evaluation.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= ldpm_pkg::MODE_1X;
      step_cnt <= '0;
    end else begin
      mode <= next_mode;
      step_cnt <= next_step_cnt;
    end
  end

  // Pump outputs; the switching clock runs only above 1x.
  // Both come from next_mode, so mode and switch enable always change together.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pump_mode <= 2'h0;
      pump_switch_enable <= 1'b0;
    end else begin
      pump_mode <= next_mode;
      pump_switch_enable <= (next_mode != ldpm_pkg::MODE_1X);
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait states: hreadyout stays high and the answer is always OKAY.
  assign addr_ok = hsel && hready && htrans[1];

  // Write data phase tracking.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Control register written in the data phase; unmapped writes are dropped.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch_mask <= ldpm_pkg::CTRL_MASK_RESET;
      force_1x <= 1'b0;
    end else if (wr_pend && wr_addr == ldpm_pkg::ADDR_CTRL) begin
      ch_mask <= hwdata[ldpm_pkg::CTRL_MASK_LSB +: CHANNELS];
      force_1x <= hwdata[ldpm_pkg::CTRL_FORCE_1X_BIT];
    end
  end

  // Read data captured at the address phase, so it stands through the data phase.
  // A read right behind a write to the same register sees the old value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= 32'h0000_0000;
      if (haddr[7:0] == ldpm_pkg::ADDR_CTRL) begin
        hrdata[ldpm_pkg::CTRL_MASK_LSB +: CHANNELS] <= ch_mask;
        hrdata[ldpm_pkg::CTRL_FORCE_1X_BIT] <= force_1x;
      end else if (haddr[7:0] == ldpm_pkg::ADDR_STATUS) begin
        hrdata[ldpm_pkg::ST_MODE_LSB +: 2] <= mode;
        hrdata[ldpm_pkg::ST_LEVEL_LSB +: 3] <= gain_level;
        hrdata[ldpm_pkg::ST_ACTIVE_BIT] <= device_active;
        hrdata[ldpm_pkg::ST_THERMAL_BIT] <= thermal_trip;
        hrdata[ldpm_pkg::ST_OPEN_LSB +: CHANNELS] <= led_open;
        hrdata[ldpm_pkg::ST_REG_LSB +: CHANNELS] <= led_in_regulation;
      end else if (haddr[7:0] == ldpm_pkg::ADDR_GAIN) begin
        hrdata[10:0] <= led_gain_x8;
      end
    end
  end

  // Handshake outputs held from flip-flops.
  // The slave never stalls and never errors, so both are constant after reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule

// ==== verification/ldpm_props.sv ====
// Checker for the LED dimming and pump mode controller.
`timescale 1ns/1ps
module ldpm_props #(
  parameter int SHUTDOWN_CYCLES = 200,
  parameter int STEP_UP_CYCLES = 20
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Inputs watched.
  input wire logic enable_dim_input,
  input wire logic [3:0] led_open,
  input wire logic pump_output_overvoltage,
  input wire logic die_over_temp,
  // Outputs watched.
  input wire logic [3:0] led_sink_enable,
  input wire logic [1:0] pump_mode,
  input wire logic pump_switch_enable,
  input wire logic [10:0] led_gain_x8,
  input wire logic device_active
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles the mode has stood, and cycles the wire has been low.
  int held;
  int low_cnt;
  logic [1:0] prev_mode;
  // Counters restart on any change, so only unbroken spans count.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held <= 0;
      low_cnt <= 0;
      prev_mode <= 2'h0;
    end else begin
      prev_mode <= pump_mode;
      held <= (pump_mode != prev_mode) ? 0 : held + 1;
      low_cnt <= enable_dim_input ? 0 : low_cnt + 1;
    end
  end
  // A wake-up is the rise of the active flag.
  sequence s_wake;
    $rose(device_active);
  endsequence
  property p_wake;
    s_wake |-> led_gain_x8 == ldpm_pkg::GAIN_FULL_X8 && pump_mode == 2'h0;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not at full gain in 1x");
  property p_halve;
    device_active && $past(device_active) && led_gain_x8 != $past(led_gain_x8)
      |-> led_gain_x8 == ($past(led_gain_x8) >> 1)
      || (led_gain_x8 == 11'h420 && $past(led_gain_x8) == 11'h021);
  endproperty
  a_halve: assert property (p_halve) else $error("gain step wrong");
  property p_delay;
    pump_mode > $past(pump_mode) |-> held >= STEP_UP_CYCLES - 2;
  endproperty
  a_delay: assert property (p_delay) else $error("step up too early");
  property p_one_step;
    pump_mode > $past(pump_mode) |-> pump_mode == $past(pump_mode) + 2'h1;
  endproperty
  a_one_step: assert property (p_one_step) else $error("mode skipped");
  property p_down;
    pump_mode < $past(pump_mode) |-> pump_mode == 2'h0;
  endproperty
  a_down: assert property (p_down) else $error("stepped down to middle mode");
  property p_ovp;
    pump_output_overvoltage |=> pump_mode == 2'h0;
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage kept mode");
  property p_all_open;
    &led_open |=> pump_mode == 2'h0;
  endproperty
  a_all_open: assert property (p_all_open) else $error("all open not 1x");
  property p_hot;
    die_over_temp |-> ##[1:2] led_sink_enable == 4'h0 && pump_mode == 2'h0;
  endproperty
  a_hot: assert property (p_hot) else $error("sinks on when hot");
  property p_switch;
    pump_switch_enable == (pump_mode != 2'h0);
  endproperty
  a_switch: assert property (p_switch) else $error("switching in 1x");
  property p_off;
    low_cnt >= SHUTDOWN_CYCLES + 2 |-> !device_active;
  endproperty
  a_off: assert property (p_off) else $error("no shutdown after long low");
  property p_sinks;
    !device_active && !$past(device_active) |-> led_sink_enable == 4'h0;
  endproperty
  a_sinks: assert property (p_sinks) else $error("sink on in shutdown");
endmodule
bind ldpm_ctrl ldpm_props #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES), .STEP_UP_CYCLES(STEP_UP_CYCLES))
  u_props (.hclk(hclk), .hresetn(hresetn), .enable_dim_input(enable_dim_input),
  .led_open(led_open), .pump_output_overvoltage(pump_output_overvoltage),
  .die_over_temp(die_over_temp), .led_sink_enable(led_sink_enable), .pump_mode(pump_mode),
  .pump_switch_enable(pump_switch_enable), .led_gain_x8(led_gain_x8),
  .device_active(device_active));

// ==== verification/ldpm_host.sv ====
// Host model that drives the one-wire enable and dimming input.
`timescale 1ns/1ps
module ldpm_host (
  // Clock.
  input wire logic hclk,
  // Wire to the device.
  output logic enable_dim_input
);
  // Low from time zero, so the device starts shut down.
  initial enable_dim_input = 1'b0;
  // Hold a level for n edges, changing it just after an edge.
  task automatic hold(input logic lvl, input int n);
    @(posedge hclk);
    enable_dim_input <= lvl;
    repeat (n) @(posedge hclk);
  endtask
  // Power on and wait before the first pulse.
  task automatic power_on;
    hold(1'b1, 250);
  endtask
  // One dimming pulse; the low stays short of the shutdown time.
  task automatic dim_pulse(input int lo);
    hold(1'b0, lo);
    hold(1'b1, 6);
  endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking testbench for the LED dimming and pump mode controller.
`timescale 1ns/1ps
module tb;
  // Clock, reset and bus.
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, dim, sw_en, active;
  logic [31:0] hrdata, rd;
  // Analog indications and controls.
  logic [3:0] reg_ok = 4'hf;
  logic [3:0] open = 4'h0;
  logic supply = 1'b0;
  logic ovp = 1'b0;
  logic hot = 1'b0;
  logic cool = 1'b0;
  logic [3:0] sinks;
  logic [1:0] mode;
  logic [10:0] gain;
  int miscompares = 0;
  int n_compared = 0;
  // Rows: low time of each pulse and the gain it should leave.
  int lo_c [7] = '{6, 9, 150, 6, 40, 6, 120};
  logic [10:0] exp_g [7] = '{11'h210, 11'h108, 11'h084, 11'h042, 11'h021, 11'h420, 11'h210};
  always #20 hclk = ~hclk;
  assign hready = hreadyout;
  ldpm_ctrl #(.SHUTDOWN_CYCLES(200), .STEP_UP_CYCLES(20)) u_ldpm_ctrl (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .enable_dim_input(dim), .led_in_regulation(reg_ok), .led_open(open),
    .supply_ok_for_1x(supply), .pump_output_overvoltage(ovp), .die_over_temp(hot),
    .die_temp_recovered(cool), .led_sink_enable(sinks), .pump_mode(mode),
    .pump_switch_enable(sw_en), .led_gain_x8(gain), .device_active(active));
  ldpm_host u_ldpm_host (.hclk(hclk), .enable_dim_input(dim));
  // Compare and count.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // One AHB single transfer; read data lands in rd.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask
  // Wait a bounded time for a pump mode.
  task automatic wait_mode(input logic [1:0] m);
    int i;
    i = 0;
    while (mode !== m && i < 60) begin
      @(posedge hclk);
      #1;
      i++;
    end
    chk(mode, m);
    chk(sw_en, m != 2'h0);
  endtask
  // Print the counts and the verdict, then end.
  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog, well past the length of all tests.
  initial begin
    #2_000_000;
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk(mode, 2'h0);
    chk(gain, 11'h420);
    chk(sinks, 4'h0);
    ahb(1'b0, ldpm_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'hf);
    ahb(1'b1, 8'h40, 32'h1234);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    $display("reset and bus test done");
    u_ldpm_host.power_on;
    #1;
    chk(gain, 11'h420);
    for (int k = 0; k < 7; k++) begin
      u_ldpm_host.dim_pulse(lo_c[k]);
      #1;
      chk(gain, exp_g[k]);
      ahb(1'b0, ldpm_pkg::ADDR_GAIN, 32'h0);
      chk(rd, {21'h0, exp_g[k]});
    end
    u_ldpm_host.dim_pulse(3);
    #1;
    chk(gain, 11'h210);
    chk(mode, 2'h0);
    $display("dimming test done");
    @(posedge hclk);
    reg_ok <= 4'h0;
    repeat (10) @(posedge hclk);
    #1;
    chk(mode, 2'h0);
    for (int m = 1; m < 4; m++) wait_mode(m[1:0]);
    repeat (40) @(posedge hclk);
    #1;
    chk(mode, 2'h3);
    @(posedge hclk);
    supply <= 1'b1;
    @(posedge hclk);
    #1;
    chk(mode, 2'h0);
    @(posedge hclk);
    supply <= 1'b0;
    wait_mode(2'h1);
    @(posedge hclk);
    ovp <= 1'b1;
    @(posedge hclk);
    ovp <= 1'b0;
    #1;
    chk(mode, 2'h0);
    wait_mode(2'h1);
    @(posedge hclk);
    open <= 4'hf;
    repeat (40) @(posedge hclk);
    #1;
    chk(mode, 2'h0);
    @(posedge hclk);
    open <= 4'h1;
    reg_ok <= 4'he;
    repeat (40) @(posedge hclk);
    #1;
    chk(mode, 2'h0);
    ahb(1'b0, ldpm_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_e124);
    @(posedge hclk);
    open <= 4'h0;
    ahb(1'b1, ldpm_pkg::ADDR_CTRL, 32'h0000_000e);
    repeat (40) @(posedge hclk);
    #1;
    chk(mode, 2'h0);
    chk(sinks, 4'he);
    ahb(1'b1, ldpm_pkg::ADDR_CTRL, 32'h0000_001f);
    ahb(1'b0, ldpm_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000_001f);
    repeat (40) @(posedge hclk);
    #1;
    chk(mode, 2'h0);
    chk(sw_en, 1'b0);
    ahb(1'b1, ldpm_pkg::ADDR_CTRL, 32'h0000_000f);
    $display("pump test done");
    @(posedge hclk);
    open <= 4'h0;
    reg_ok <= 4'hf;
    hot <= 1'b1;
    repeat (3) @(posedge hclk);
    #1;
    chk(sinks, 4'h0);
    @(posedge hclk);
    hot <= 1'b0;
    cool <= 1'b1;
    repeat (3) @(posedge hclk);
    #1;
    chk(sinks, 4'hf);
    @(posedge hclk);
    cool <= 1'b0;
    u_ldpm_host.hold(1'b0, 210);
    #1;
    chk(active, 1'b0);
    chk(sinks, 4'h0);
    chk(gain, 11'h420);
    u_ldpm_host.power_on;
    #1;
    chk(active, 1'b1);
    chk(gain, 11'h420);
    $display("fault and shutdown test done");
    stop_test;
  end
endmodule
